// ---- addr_decode_pkg.sv ----
package addr_decode_pkg;

  // data space map
  localparam logic [15:0] RAM_BASE       = 16'hfb00;
  localparam logic [15:0] RAM_TOP        = 16'hfeff;
  localparam logic [15:0] MAIN_RAM_BASE  = 16'hfe00;
  localparam logic [15:0] SPECIAL_BASE   = 16'hff00;
  localparam logic [15:0] SPECIAL_TOP    = 16'hffff;
  localparam logic [15:0] SHORT_LOW_PAGE = 16'hfe00;
  localparam logic [15:0] SHORT_HI_PAGE  = 16'hff00;
  localparam logic [7:0]  SHORT_SPLIT    = 8'h20;
  localparam logic [15:0] ROM_TOP        = 16'h7fff;

  // general register file shape
  localparam int BANK_COUNT    = 8;
  localparam int BYTE_REGS     = 16;
  localparam int GREG_IDX_W    = 8;

  // operand addressing modes
  typedef enum logic [1:0] {
    MODE_DIRECT,
    MODE_SHORT,
    MODE_SPECIAL,
    MODE_GREG
  } addr_mode_t;

  // request from the execution unit
  typedef struct packed {
    logic       valid;
    addr_mode_t mode;
    logic       word;
    logic [15:0] direct_addr;
    logic [7:0] operand;
    logic [3:0] reg_field;
    logic [2:0] bank_sel;
    logic       register_set_select_flag;
  } decode_req_t;

  // decoded access
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic        word;
    logic        sel_ram;
    logic        sel_special;
    logic        sel_rom;
    logic        sel_external;
    logic        sel_greg;
    logic [7:0]  greg_index;
    logic        align_err;
  } decode_rsp_t;

endpackage : addr_decode_pkg

// ---- addr_decode_props.sv ----
`timescale 1ns/100ps
`default_nettype none
// ties each decoded answer to the request taken one edge before
module addr_decode_props
  import addr_decode_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        external_rom_select_n,
  input wire decode_req_t req,
  input wire decode_rsp_t rsp
);
  decode_req_t p_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // copy of the last request, cleared so no stale cause survives reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) p_q <= '0;
    else p_q <= req;
  end
  AST_RAM: assert property (rsp.valid && !rsp.sel_greg && rsp.addr inside {[16'hfb00:16'hfeff]}
    |-> rsp.sel_ram && !rsp.sel_special) else $error("ram not selected");
  AST_SPECIAL: assert property (rsp.valid && !rsp.sel_greg && rsp.addr >= 16'hff00
    |-> rsp.sel_special && !rsp.sel_ram) else $error("special not selected");
  AST_SHORT_PAGE: assert property (p_q.valid && p_q.mode == MODE_SHORT |-> rsp.addr[7:1] == p_q.operand[7:1]
    && rsp.addr[15:8] == (p_q.operand < 8'h20 ? 8'hff : 8'hfe)) else $error("short page wrong");
  AST_PAIR: assert property (p_q.valid && p_q.word && p_q.mode inside {MODE_SHORT, MODE_SPECIAL}
    |-> rsp.word && !rsp.addr[0]) else $error("word pair not even");
  AST_SPEC_ADDR: assert property (p_q.valid && p_q.mode == MODE_SPECIAL
    |-> rsp.sel_special && rsp.addr[15:1] == {8'hff, p_q.operand[7:1]}) else $error("special addr");
  AST_GREG_BYTE: assert property (p_q.valid && p_q.mode == MODE_GREG && !p_q.word
    |-> rsp.sel_greg && rsp.greg_index == {1'b0, p_q.bank_sel, p_q.reg_field}) else $error("greg byte");
  AST_GREG_WORD: assert property (p_q.valid && p_q.mode == MODE_GREG && p_q.word && !p_q.register_set_select_flag
    |-> rsp.greg_index == {1'b0, p_q.bank_sel, p_q.reg_field[2:0], 1'b0}) else $error("greg word");
  // the pin crosses two flops, so it must have been low for a while
  AST_EXT_ROM: assert property (rsp.valid && !rsp.sel_greg && rsp.addr <= 16'h7fff
    && !$past(external_rom_select_n, 2) && !$past(external_rom_select_n, 3)
    |-> rsp.sel_external && !rsp.sel_rom) else $error("rom not external");
endmodule : addr_decode_props
bind data_memory_address_decoder addr_decode_props u_props (.clk(clk), .rst_n(rst_n),
  .external_rom_select_n(external_rom_select_n), .req(req), .rsp(rsp));
`default_nettype wire

// ---- data_memory_address_decoder.sv ----
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - addresses FB00H through FEFFH select the internal RAM.
// - addresses FF00H through FFFFH select the special register area instead of RAM.
// - a one-byte short-direct operand picks a location in FE20H to FF1FH, byte or word wide.
// - a word short-direct access with an even operand moves the even byte then the odd one.
// - special-register addressing takes the operand byte as the low 8 bits within FF00H-FFFFH.
// - a word access to a word special register moves the even byte with the next odd byte.
// - the general registers are eight banks of sixteen bytes or eight words.
// - a general register is chosen by the register field and three bank flags, plus the set flag for word registers.
// - with external_rom_select_n low or on the ROM-less build, ROM space goes to external memory.
module data_memory_address_decoder
  import addr_decode_pkg::*;
#(
  parameter bit HAS_ROM = 1'b1
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // external rom select pin
  input  wire logic        external_rom_select_n,
  // request from the execution unit
  input  wire decode_req_t req,
  // decoded access, one cycle later
  output      decode_rsp_t rsp
);

  logic        rst_s1_q;
  logic        rst_s2_q;
  logic        ea_s1_q;
  logic        ea_s2_q;
  logic [15:0] addr;
  logic [7:0]  greg_index;
  decode_rsp_t rsp_d;
  decode_rsp_t rsp_q;

  // reset release synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // pin synchroniser; the pin is a static strap but may move at power-up
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      ea_s1_q <= 1'b0;
      ea_s2_q <= 1'b0;
    end else begin
      ea_s1_q <= external_rom_select_n;
      ea_s2_q <= ea_s1_q;
    end
  end

  // short-direct operand to full address
  function automatic logic [15:0] short_addr(input logic [7:0] op);
    if (op >= SHORT_SPLIT) begin
      short_addr = SHORT_LOW_PAGE | {8'h00, op};
    end else begin
      short_addr = SHORT_HI_PAGE | {8'h00, op};
    end
  endfunction : short_addr

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  greg_select u_greg_select (
    .reg_field                (req.reg_field),
    .word                     (req.word),
    .bank_sel                 (req.bank_sel),
    .register_set_select_flag (req.register_set_select_flag),
    .greg_index               (greg_index)
  );

  // effective address by mode
  always_comb begin
    unique case (req.mode)
      MODE_DIRECT:  addr = req.direct_addr;
      MODE_SHORT:   addr = short_addr(req.operand);
      MODE_SPECIAL: addr = SPECIAL_BASE | {8'h00, req.operand};
      MODE_GREG:    addr = 16'h0000;
    endcase
  end

  // region decode; word accesses keep the even base so the bus moves base then base+1
  always_comb begin
    rsp_d              = '0;
    rsp_d.valid        = req.valid;
    rsp_d.word         = req.word;
    rsp_d.addr         = req.word ? {addr[15:1], 1'b0} : addr;
    if (req.mode == MODE_GREG) begin
      rsp_d.sel_greg   = 1'b1;
      rsp_d.greg_index = greg_index;
    end else if (in_range(addr, SPECIAL_BASE, SPECIAL_TOP)) begin
      rsp_d.sel_special = 1'b1;
    end else if (in_range(addr, RAM_BASE, RAM_TOP)) begin
      rsp_d.sel_ram    = 1'b1;
    end else if (addr <= ROM_TOP && HAS_ROM && ea_s2_q) begin
      rsp_d.sel_rom    = 1'b1;
    end else begin
      rsp_d.sel_external = 1'b1;
    end
    // odd short-direct word operand, or odd direct word address in FE00H-FEFFH, is the execution unit's fault; flag it, never split it
    if (req.mode == MODE_SHORT && req.word && req.operand[0]) begin
      rsp_d.align_err  = 1'b1;
    end
    if (req.mode == MODE_DIRECT && req.word && addr[0] && in_range(addr, MAIN_RAM_BASE, RAM_TOP)) begin
      rsp_d.align_err  = 1'b1;
    end
    if (!req.valid) begin
      rsp_d = '0;
    end
  end

  // registered response
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign rsp = rsp_q;

endmodule : data_memory_address_decoder
`default_nettype wire

// ---- data_memory_address_decoder_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module data_memory_address_decoder_bench;
  import addr_decode_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        ext_n;
  decode_req_t req;
  decode_rsp_t rsp;
  int          fails;
  int          n_tests;
  exec_model m (.clk(clk), .req(req));
  data_memory_address_decoder dut (.clk(clk), .rst_n(rst_n), .external_rom_select_n(ext_n), .req(req), .rsp(rsp));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // one request, answer judged one edge later; es is {ram,special,rom,ext,greg}
  task t(input addr_mode_t md, input logic w, input logic [15:0] a, input logic [7:0] op, input logic [3:0] rf,
         input logic [2:0] bk, input logic rs, input logic [15:0] ea, input logic [15:0] es);
    m.send(md, w, a, op, rf, bk, rs);
    @(posedge clk);
    #1;
    check(md == MODE_GREG ? {8'h0, rsp.greg_index} : rsp.addr, ea);
    check({11'h0, rsp.sel_ram, rsp.sel_special, rsp.sel_rom, rsp.sel_external, rsp.sel_greg}, es);
    check({13'h0, rsp.valid, rsp.word, rsp.align_err}, {13'h0, 1'b1, w, 1'b0});
  endtask : t
  task sc_map;
    t(MODE_DIRECT, 0, 16'hfb00, 0, 0, 0, 0, 16'hfb00, 5'b10000);
    t(MODE_DIRECT, 0, 16'hfeff, 0, 0, 0, 0, 16'hfeff, 5'b10000);
    t(MODE_DIRECT, 0, 16'hff00, 0, 0, 0, 0, 16'hff00, 5'b01000);
    t(MODE_DIRECT, 0, 16'hffff, 0, 0, 0, 0, 16'hffff, 5'b01000);
    t(MODE_DIRECT, 0, 16'h7fff, 0, 0, 0, 0, 16'h7fff, 5'b00100);
  endtask : sc_map
  task sc_short;
    t(MODE_SHORT, 0, 0, 8'h20, 0, 0, 0, 16'hfe20, 5'b10000);
    t(MODE_SHORT, 0, 0, 8'hff, 0, 0, 0, 16'hfeff, 5'b10000);
    t(MODE_SHORT, 0, 0, 8'h00, 0, 0, 0, 16'hff00, 5'b01000);
    t(MODE_SHORT, 0, 0, 8'h1f, 0, 0, 0, 16'hff1f, 5'b01000);
    t(MODE_SHORT, 1, 0, 8'h1e, 0, 0, 0, 16'hff1e, 5'b01000);
  endtask : sc_short
  task sc_special;
    t(MODE_SPECIAL, 0, 0, 8'hc1, 0, 0, 0, 16'hffc1, 5'b01000);
    t(MODE_SPECIAL, 1, 0, 8'hc0, 0, 0, 0, 16'hffc0, 5'b01000);
  endtask : sc_special
  task sc_greg;
    t(MODE_GREG, 0, 0, 0, 4'hf, 3'h7, 0, 16'h7f, 5'b00001);
    t(MODE_GREG, 0, 0, 0, 4'h3, 3'h0, 1, 16'h03, 5'b00001);
    t(MODE_GREG, 1, 0, 0, 4'h5, 3'h2, 0, 16'h2a, 5'b00001);
    t(MODE_GREG, 1, 0, 0, 4'h5, 3'h2, 1, 16'h22, 5'b00001);
  endtask : sc_greg
  // pin low hands rom space to external memory after the two-flop delay
  task sc_ext;
    @(posedge clk);
    ext_n <= 1'b0;
    repeat (5) @(posedge clk);
    t(MODE_DIRECT, 0, 16'h0100, 0, 0, 0, 0, 16'h0100, 5'b00010);
  endtask : sc_ext
  task summarize;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial begin
    rst_n = 1'b0;
    ext_n = 1'b1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    sc_map();
    sc_short();
    sc_special();
    sc_greg();
    sc_ext();
    summarize();
  end
endmodule : data_memory_address_decoder_bench
`default_nettype wire

// ---- exec_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// execution unit stand-in: issues one operand request per call
module exec_model
  import addr_decode_pkg::*;
(
  input  wire logic    clk,
  output var decode_req_t req
);
  initial req = '0;
  // word requests are always made even, as the real unit guarantees
  task send(input addr_mode_t md, input logic w, input logic [15:0] a, input logic [7:0] op,
            input logic [3:0] rf, input logic [2:0] bk, input logic rs);
    @(posedge clk);
    req <= '{1'b1, md, w, a & {15'h7fff, !w}, op & {7'h7f, !w}, rf, bk, rs};
  endtask : send
endmodule : exec_model
`default_nettype wire

// ---- greg_select.sv ----
`timescale 1ns/100ps
`default_nettype none

// general register index: bank in the top bits, then register within bank
module greg_select
  import addr_decode_pkg::*;
(
  // selection inputs
  input  wire logic [3:0]            reg_field,
  input  wire logic                  word,
  input  wire logic [2:0]            bank_sel,
  input  wire logic                  register_set_select_flag,
  // byte index into the register file
  output      logic [GREG_IDX_W-1:0] greg_index
);

  logic [3:0] byte_reg;

  // word registers use a 3-bit field and name the even byte of a pair;
  // the set flag swaps the upper and lower half of each bank for words,
  // so the index never leaves the sixteen bytes of the selected bank
  always_comb begin
    if (word) begin
      byte_reg = {reg_field[2:0], 1'b0} ^ {register_set_select_flag, 3'b000};
    end else begin
      byte_reg = reg_field;
    end
    greg_index = {1'b0, bank_sel, byte_reg};
  end

endmodule : greg_select
`default_nettype wire
